// [logic/rxm_error_mask.sv]
// Receive error mask, carrier sense and loopback transmit control block
//
// Contract
// RQ1 - Alternate bit set, full duplex: carrier sense follows own transmit only.
// RQ2 - Alternate bit clear, full duplex: carrier sense follows line reception only.
// RQ3 - Transmit-disable bit set (reset value): line transmit off during loopback.
// RQ4 - Transmit-disable bit clear: line transmit stays driven during loopback.
// RQ5 - Software clears transmit-disable before selecting transceiver loopback.
// RQ6 - Code error: error flag high, nibble 5h if select set, else 6h.
// RQ7 - Premature end: error flag high, nibble 4h if select set, else 6h.
// RQ8 - Two idles inside a frame before the end delimiter mean premature end.
// RQ9 - Link error enable set: nibble 3h with error flag; clear: data unchanged.
// RQ10 - Packet error enable set: nibble 2h with error flag; clear: unchanged.
// RQ11 - Software writes zero to bit 0 and ignores its read value.
// RQ12 - Alignment bypass set: receive nibble and error flag never modified.
// RQ13 - Substitution rides on the same cycle as the affected symbol.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module rxm_error_mask
  import rxm_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Link state
  input  wire logic              full_duplex,
  input  wire logic              speed_10,
  input  wire logic              loopback_active,
  input  wire logic              tx_active,
  input  wire logic              fast_rx_active,
  input  wire logic              slow_line_receive_active,
  output logic                   carrier_sense,
  output logic                   line_transmit_pair_enable,
  // Decoded receive symbols
  input  wire rxm_sym_type       sym_in,
  input  wire logic              sym_valid,
  output logic                   sym_ready,
  // Toward the MAC
  output rxm_mii_type            mii_out,
  output logic                   mii_valid,
  input  wire logic              mii_ready
);

  logic [REG_W-1:0]  loopback_bypass_rx_error_mask_reg;
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [REG_W-1:0]  wdata_reg;
  logic [1:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              commit;
  logic [REG_W-1:0]  merged;
  logic              alternate_carrier_sense;
  logic              loopback_transmit_disable;
  logic              code_value_select;
  logic              premature_end_value_select;
  logic              link_error_report_enable;
  logic              packet_error_report_enable;
  logic              symbol_alignment_bypass;
  logic              carrier_sense_reg;
  logic              line_tx_en_reg;
  logic              rx_line_active;
  logic              carrier_next;
  rxm_pe_state_type  pe_state_reg;
  logic              idle_seen_reg;
  logic              accept;
  logic              pe_hit;
  rxm_mii_type       mapped;

  // Field decode
  assign alternate_carrier_sense =
    loopback_bypass_rx_error_mask_reg[BIT_ALT_SENSE];
  assign loopback_transmit_disable =
    loopback_bypass_rx_error_mask_reg[BIT_LTD];
  assign code_value_select =
    loopback_bypass_rx_error_mask_reg[BIT_CODE_SEL];
  assign premature_end_value_select =
    loopback_bypass_rx_error_mask_reg[BIT_PE_SEL];
  assign link_error_report_enable =
    loopback_bypass_rx_error_mask_reg[BIT_LINK_EN];
  assign packet_error_report_enable =
    loopback_bypass_rx_error_mask_reg[BIT_PKT_EN];
  assign symbol_alignment_bypass =
    loopback_bypass_rx_error_mask_reg[BIT_ALIGN_BYP];

  // Write channel handshakes; each side held until the write commits
  assign s_axi_awready = !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign commit        = aw_got_reg && w_got_reg && !bvalid_reg;

  // Address and data captured independently, either order
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg  <= '0;
      wstrb_reg  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (commit) begin
        aw_got_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[REG_W-1:0];
        wstrb_reg <= s_axi_wstrb[1:0];
      end else if (commit) begin
        w_got_reg <= 1'b0;
      end
    end
  end

  // Byte lanes merged over the stored value
  always_comb begin
    merged = loopback_bypass_rx_error_mask_reg;
    if (wstrb_reg[0]) begin
      merged[7:0] = wdata_reg[7:0];
    end
    if (wstrb_reg[1]) begin
      merged[15:8] = wdata_reg[15:8];
    end
  end

  // Register store; reserved and unused bits never stored
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      loopback_bypass_rx_error_mask_reg <= REG_RESET; // RQ3
    end else if (commit && awaddr_reg == ADDR_MASK_REG) begin
      loopback_bypass_rx_error_mask_reg <= merged & REG_WMASK; // RQ11
    end
  end

  // Write response; unmapped address answers with slave error
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (commit) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (awaddr_reg == ADDR_MASK_REG) ? RESP_OKAY
                                                  : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel; one read in flight, bit 0 reads as zero
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      if (s_axi_araddr == ADDR_MASK_REG) begin
        rresp_reg <= RESP_OKAY;
        rdata_reg <= {16'h0000, loopback_bypass_rx_error_mask_reg};
      end else begin
        rresp_reg <= RESP_SLVERR;
        rdata_reg <= '0;
      end
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Carrier sense; half duplex keeps both sources
  assign rx_line_active = speed_10 ? slow_line_receive_active
                                   : fast_rx_active;
  always_comb begin
    if (!full_duplex) begin
      carrier_next = tx_active || rx_line_active;
    end else if (alternate_carrier_sense) begin
      carrier_next = tx_active; // RQ1
    end else begin
      carrier_next = rx_line_active; // RQ2
    end
  end

  // Registered pin drivers, one cycle behind their causes
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      carrier_sense_reg <= 1'b0;
      line_tx_en_reg    <= 1'b1;
    end else begin
      carrier_sense_reg <= carrier_next;
      // RQ3 RQ4; transceiver loopback relies on software, see RQ5
      line_tx_en_reg <= !(loopback_active && loopback_transmit_disable);
    end
  end
  assign carrier_sense             = carrier_sense_reg;
  assign line_transmit_pair_enable = line_tx_en_reg;

  // Symbols move only when the buffer has room
  assign accept = sym_valid && sym_ready;
  assign pe_hit = (pe_state_reg == PE_FRAME) && sym_in.idle &&
                  idle_seen_reg; // RQ8

  // Frame tracker for premature end detection
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pe_state_reg  <= PE_OUTSIDE;
      idle_seen_reg <= 1'b0;
    end else if (accept) begin
      case (pe_state_reg)
        PE_OUTSIDE: begin
          idle_seen_reg <= 1'b0;
          if (sym_in.dv && !sym_in.idle) begin
            pe_state_reg <= PE_FRAME;
          end
        end
        PE_FRAME: begin
          if (sym_in.esd_t) begin
            pe_state_reg  <= PE_GOT_T;
            idle_seen_reg <= 1'b0;
          end else if (pe_hit) begin
            pe_state_reg  <= PE_OUTSIDE; // RQ8
            idle_seen_reg <= 1'b0;
          end else begin
            idle_seen_reg <= sym_in.idle;
          end
        end
        PE_GOT_T: begin
          // T without R falls back into the frame
          pe_state_reg  <= sym_in.esd_r ? PE_OUTSIDE : PE_FRAME;
          idle_seen_reg <= sym_in.idle;
        end
        default: begin
          pe_state_reg  <= PE_OUTSIDE;
          idle_seen_reg <= 1'b0;
        end
      endcase
    end
  end

  // Error mapping, applied to the symbol it belongs to
  always_comb begin
    mapped.rxd   = sym_in.data;
    mapped.rx_er = 1'b0;
    mapped.rx_dv = sym_in.dv;
    if (symbol_alignment_bypass) begin
      mapped.rxd   = sym_in.data; // RQ12
      mapped.rx_er = 1'b0;
    end else if (sym_in.link_err && link_error_report_enable) begin
      mapped.rxd   = NIB_LINK; // RQ9 RQ13
      mapped.rx_er = 1'b1;
    end else if (sym_in.pkt_timeout && packet_error_report_enable) begin
      mapped.rxd   = NIB_PKT; // RQ10 RQ13
      mapped.rx_er = 1'b1;
    end else if (pe_hit) begin
      mapped.rxd   = premature_end_value_select ? NIB_PE_SET
                                                : NIB_DEFAULT; // RQ7
      mapped.rx_er = 1'b1;
    end else if (sym_in.code_err) begin
      mapped.rxd   = code_value_select ? NIB_CODE_SET
                                       : NIB_DEFAULT; // RQ6
      mapped.rx_er = 1'b1;
    end
  end

  // A stall by the MAC side reaches the symbol source
  rxm_buffer #(
    .WIDTH ($bits(rxm_mii_type))
  ) u_buffer (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .in_valid  (sym_valid),
    .in_ready  (sym_ready),
    .in_data   (mapped),
    .out_valid (mii_valid),
    .out_ready (mii_ready),
    .out_data  (mii_out)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_crs_alt_tx: assert property ( // RQ1
    full_duplex && alternate_carrier_sense && !tx_active
    |=> !carrier_sense)
    else $error("carrier sense from reception in alternate mode");
  a_crs_rx_only: assert property ( // RQ2
    full_duplex && !alternate_carrier_sense
    |=> carrier_sense == $past(rx_line_active))
    else $error("carrier sense not following reception");
  a_tx_disabled: assert property ( // RQ3
    loopback_active && loopback_transmit_disable
    |=> !line_transmit_pair_enable)
    else $error("line transmit driven during loopback");
  a_tx_kept_on: assert property ( // RQ4
    !loopback_transmit_disable |=> line_transmit_pair_enable)
    else $error("line transmit dropped with disable clear");
  a_code_nibble: assert property ( // RQ6
    accept && !symbol_alignment_bypass && sym_in.code_err &&
    !sym_in.link_err && !sym_in.pkt_timeout && !pe_hit && mii_ready &&
    mii_valid == 1'b0
    |=> mii_valid && mii_out.rx_er &&
        mii_out.rxd == (code_value_select ? NIB_CODE_SET
                                          : NIB_DEFAULT))
    else $error("code error nibble wrong");
  a_pe_two_idles: assert property ( // RQ8
    accept && pe_state_reg == PE_FRAME && !sym_in.esd_t && !pe_hit &&
    sym_in.idle ##1 accept && sym_in.idle && !sym_in.esd_t
    |-> pe_hit)
    else $error("premature end missed");
  a_pe_nibble: assert property ( // RQ7
    accept && pe_hit && !symbol_alignment_bypass &&
    !sym_in.link_err && !sym_in.pkt_timeout
    |-> mapped.rx_er && mapped.rxd == (premature_end_value_select ?
        NIB_PE_SET : NIB_DEFAULT))
    else $error("premature end nibble wrong");
  a_link_nibble: assert property ( // RQ9
    accept && sym_in.link_err && link_error_report_enable &&
    !symbol_alignment_bypass && !mii_valid
    |=> mii_out.rxd == NIB_LINK && mii_out.rx_er)
    else $error("link error nibble wrong");
  a_pkt_nibble: assert property ( // RQ10
    accept && sym_in.pkt_timeout && packet_error_report_enable &&
    !sym_in.link_err && !symbol_alignment_bypass && !mii_valid
    |=> mii_out.rxd == NIB_PKT && mii_out.rx_er)
    else $error("packet error nibble wrong");
  a_bypass_clean: assert property ( // RQ12
    accept && symbol_alignment_bypass && !mii_valid
    |=> !mii_out.rx_er && mii_out.rxd == $past(sym_in.data))
    else $error("data modified in alignment bypass");
  a_reserved_zero: assert property ( // RQ11
    s_axi_rvalid |-> s_axi_rdata[0] == 1'b0)
    else $error("reserved bit reads nonzero");

  c_write_done: cover property (commit ##[1:4] s_axi_bvalid);
  c_pe_event: cover property (accept && pe_hit);
  c_stall_full: cover property (!sym_ready ##1 sym_ready);
  c_alt_sense: cover property (full_duplex && alternate_carrier_sense
                             && tx_active ##1 carrier_sense);

endmodule
`default_nettype wire

// [logic/rxm_pkg.sv]
// Constants, field layout and carrier types for the receive error mask block
package rxm_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 16;

  // Byte address of the loopback, bypass and error mask register
  localparam logic [ADDR_W-1:0] ADDR_MASK_REG = 8'h18;

  // Field positions
  localparam int unsigned BIT_PKT_EN    = 1;
  localparam int unsigned BIT_LINK_EN   = 2;
  localparam int unsigned BIT_PE_SEL    = 3;
  localparam int unsigned BIT_CODE_SEL  = 4;
  localparam int unsigned BIT_LTD       = 5;
  localparam int unsigned BIT_ALT_SENSE = 6;
  localparam int unsigned BIT_ALIGN_BYP = 12;

  // Reset value and writable bits (bit 0 is reserved, never stored)
  localparam logic [REG_W-1:0] REG_RESET = 16'h0020;
  localparam logic [REG_W-1:0] REG_WMASK = 16'h107e;

  // Substitute nibbles
  localparam logic [3:0] NIB_CODE_SET = 4'h5;
  localparam logic [3:0] NIB_DEFAULT  = 4'h6;
  localparam logic [3:0] NIB_PE_SET   = 4'h4;
  localparam logic [3:0] NIB_LINK     = 4'h3;
  localparam logic [3:0] NIB_PKT      = 4'h2;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Buffer depth
  localparam int unsigned BUF_DEPTH = 2;

  // One received symbol from the decoder, with its error flags
  typedef struct packed {
    logic [3:0] data;
    logic       dv;
    logic       code_err;
    logic       link_err;
    logic       pkt_timeout;
    logic       idle;
    logic       esd_t;
    logic       esd_r;
  } rxm_sym_type;

  // One nibble toward the MAC
  typedef struct packed {
    logic [3:0] rxd;
    logic       rx_er;
    logic       rx_dv;
  } rxm_mii_type;

  // Premature end tracking
  typedef enum logic [1:0] {
    PE_OUTSIDE,
    PE_FRAME,
    PE_GOT_T
  } rxm_pe_state_type;

endpackage

// [logic/rxm_buffer.sv]
// Two-entry valid/ready buffer between the error mapper and the MAC side
`timescale 1ns/1ns
`default_nettype none
module rxm_buffer
  import rxm_pkg::*;
#(
  parameter int unsigned WIDTH = 6
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_reg [BUF_DEPTH];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  // Full and empty straight from the occupancy count
  assign in_ready  = (count_reg != 2'(BUF_DEPTH));
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage, written at the write index
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count; push and pop may share a cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule
`default_nettype wire

// [verification/rxm_mac_model.sv]
// MAC-side sink model for the receive nibble stream
`timescale 1ns/1ns
`default_nettype none
module rxm_mac_model
  import rxm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire rxm_mii_type mii_out,
  input  wire logic        mii_valid,
  output logic             mii_ready,
  input  wire logic        stall
);
  // Nibbles taken from the PHY side, oldest first
  rxm_mii_type got[$];

  // Ready lags stall by one edge, like a MAC whose FIFO fills up
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mii_ready <= 1'b0;
    end else begin
      mii_ready <= !stall;
    end
  end

  // Take a nibble only at a handshake edge, so order is kept
  always @(posedge ref_clk) begin
    if (!reset && mii_valid && mii_ready) begin
      got.push_back(mii_out);
    end
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Register, carrier, loopback and error mapping tests
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import rxm_pkg::*;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic [3:0]        wstrb = '0;
  logic              awvalid = 0, wvalid = 0, bready = 0;
  logic              arvalid = 0, rready = 0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              fdx = 1, spd = 0, lbk = 0, txa = 0, frx = 0, srx = 0;
  logic              crs, lt_en, sym_valid = 0, sym_ready, stall = 0;
  rxm_sym_type       sym_in = '0;
  rxm_mii_type       mii_out;
  logic              mii_valid, mii_ready;
  int                err_total = 0, total_checks = 0;
  logic [31:0]       d;
  logic [1:0]        r;

  always #25 ref_clk = ~ref_clk;

  rxm_error_mask dut (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .full_duplex(fdx),
    .speed_10(spd), .loopback_active(lbk), .tx_active(txa),
    .fast_rx_active(frx), .slow_line_receive_active(srx),
    .carrier_sense(crs), .line_transmit_pair_enable(lt_en),
    .sym_in(sym_in), .sym_valid(sym_valid), .sym_ready(sym_ready),
    .mii_out(mii_out), .mii_valid(mii_valid), .mii_ready(mii_ready));

  rxm_mac_model mac (.ref_clk(ref_clk), .reset(reset), .mii_out(mii_out),
    .mii_valid(mii_valid), .mii_ready(mii_ready), .stall(stall));

  task automatic fail(input string msg);
    err_total++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
  endtask

  task automatic chk_mii(input logic [3:0] rxd, input logic er,
                         input logic dv);
    logic [5:0] w;
    int         n;
    n = 0;
    while (mac.got.size() == 0 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    w = 'x;
    if (mac.got.size() != 0) w = mac.got.pop_front();
    total_checks++;
    if (w !== {rxd, er, dv}) fail($sformatf("nibble %h exp %h", w,
                                            {rxd, er, dv}));
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    logic aw_done, w_done, aw_hit, w_hit;
    aw_done = 0;
    w_done = 0;
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1; wdata <= v; wstrb <= 4'h3; wvalid <= 1;
    bready <= 1;
    while (!(aw_done && w_done)) begin
      @(negedge ref_clk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge ref_clk);
      if (aw_hit) begin
        awvalid <= 0;
        aw_done = 1;
      end
      if (w_hit) begin
        wvalid <= 0;
        w_done = 1;
      end
    end
    do @(negedge ref_clk); while (!bvalid);
    resp = bresp;
    @(posedge ref_clk);
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge ref_clk); while (!arready);
    @(posedge ref_clk);
    arvalid <= 0;
    do @(negedge ref_clk); while (!rvalid);
    v = rdata;
    resp = rresp;
    @(posedge ref_clk);
    rready <= 0;
  endtask

  task automatic wreg(input logic [15:0] v);
    logic [1:0] rs;
    axi_wr(ADDR_MASK_REG, {16'h0, v}, rs);
  endtask

  // Flags are {code, link, pkt, idle, end_t, end_r}
  // Called just after an edge; returns at the accepting edge, so a
  // following call streams back to back as the idle detector needs
  task automatic send(input logic [3:0] dt, input logic dv,
                      input logic [5:0] f);
    sym_in <= {dt, dv, f};
    sym_valid <= 1;
    do @(negedge ref_clk); while (!sym_ready);
    @(posedge ref_clk);
  endtask

  // Release the stream at the edge of the last accepted symbol
  task automatic send_end;
    sym_valid <= 0;
    sym_in <= ~sym_in;
  endtask

  task automatic run1(input logic [15:0] v, input logic [3:0] dt,
                      input logic [5:0] f, input logic [3:0] x,
                      input logic er);
    wreg(v);
    send(dt, 1'b1, f);
    send_end();
    chk_mii(x, er, 1'b1);
  endtask

  // Two idles after a data nibble; end delimiter pair optional
  task automatic pe_seq(input logic [15:0] v, input logic esd,
                        input logic [3:0] x, input logic er);
    wreg(v);
    send(4'h7, 1, 0);
    if (esd) send(4'h0, 0, 6'h02);
    if (esd) send(4'h0, 0, 6'h01);
    send(4'h0, 0, 6'h04);
    send(4'h0, 0, 6'h04);
    send_end();
    chk_mii(4'h7, 0, 1);
    if (esd) chk_mii(4'h0, 0, 0);
    if (esd) chk_mii(4'h0, 0, 0);
    chk_mii(4'h0, 0, 0);
    chk_mii(x, er, 0);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail("timeout");
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 0;
    axi_rd(8'h18, d, r);
    chk("reset value", d, 32'h20);
    chk("read resp", r, RESP_OKAY);
    axi_wr(8'h18, 32'hfffe, r);
    axi_rd(8'h18, d, r);
    chk("writable", d & 32'hfffe, 32'h107e);
    axi_wr(8'h1c, 32'h0, r);
    chk("bad write", r, RESP_SLVERR);
    axi_rd(8'h1c, d, r);
    chk("bad read", {d[29:0], r}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    // Third pass is half duplex, where both sources raise carrier sense
    for (int a = 0; a < 3; a++) begin
      wreg(a != 0 ? 16'h0060 : 16'h0020);
      fdx <= (a != 2);
      for (int i = 0; i < 16; i++) begin
        @(posedge ref_clk);
        {spd, txa, frx, srx} <= i[3:0];
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("crs", crs, (a == 1) ? i[2] :
            ((a == 2 && i[2]) || (i[3] ? i[0] : i[1])));
      end
    end
    $display("test carrier done");
    for (int j = 0; j < 4; j++) begin
      wreg(j[1] ? 16'h0020 : 16'h0000);
      @(posedge ref_clk);
      lbk <= j[0];
      fdx <= 1'b1;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("tx enable", lt_en, !(j[0] && j[1]));
    end
    lbk <= 0;
    $display("test loopback done");
    run1(16'h0030, 4'h9, 6'h20, 4'h5, 1);
    run1(16'h0020, 4'h9, 6'h20, 4'h6, 1);
    run1(16'h0024, 4'h9, 6'h10, 4'h3, 1);
    run1(16'h0020, 4'h9, 6'h10, 4'h9, 0);
    run1(16'h0022, 4'ha, 6'h08, 4'h2, 1);
    run1(16'h0020, 4'ha, 6'h08, 4'ha, 0);
    run1(16'h1034, 4'h9, 6'h30, 4'h9, 0);
    pe_seq(16'h0028, 0, 4'h4, 1);
    pe_seq(16'h0020, 0, 4'h6, 1);
    pe_seq(16'h0028, 1, 4'h0, 0);
    $display("test error map done");
    wreg(16'h0020);
    @(posedge ref_clk);
    stall <= 1;
    fork
      begin
        send(4'h1, 1, 0);
        send(4'h2, 1, 0);
        send(4'h3, 1, 0);
        send_end();
      end
      begin
        repeat (10) @(negedge ref_clk);
        chk("buffer full", sym_ready, 0);
        @(posedge ref_clk);
        stall <= 0;
      end
    join
    chk_mii(4'h1, 0, 1);
    chk_mii(4'h2, 0, 1);
    chk_mii(4'h3, 0, 1);
    @(negedge ref_clk);
    chk("drained", mii_valid, 0);
    $display("test buffer done");
    report_and_stop();
  end
endmodule
`default_nettype wire
